//--- core/pbi_top.sv
// Function
// R01: Upper five address bits select plug-in region
// R02: Level code readable at its address
// R03: One-hot level encoded to BCD
// R04: Over-range clears bit seven
// R05: Byte latched on send strobe rising
// R06: Send strobe rising raises receive interrupt
// R07: Port A read pulses control low when no other plug-in listens
// R08: Port A pulse drives data-valid low
// R09: Port B write starts source handshake when another plug-in listens
// R10: Data-valid asserted after port B pulse
// R11: Listener releases not-accepted after taking byte
// R12: Not-accepted rising ends handshake
// R13: Data-valid release signals completion
// R14: Handshake finish raises port A interrupt
// R15: Clearing abort bit forces handshake idle
// R16: Service request raises port B interrupt
// R17: Bus control writable at its address
// R18: Control written on gated mid-cycle strobe
// R19: Bits zero to three drive lines
// R20: Bits four to seven drive inverted lines
// R21: End-identify driven only during handshake
// R22: Reset clears interface logic
// R23: After reset handshake idle, drivers off
`timescale 1ns/100ps

module pbi_top
  import pbi_pkg::*;
(
  input wire logic core_clk_i, // 250 MHz core clock
  input wire logic rst_i, // Synchronous system reset
  input wire logic ce_i, // Clock enable, freezes state
  input wire logic [ADDR_W-1:0] cpu_addr_i, // Processor address
  input wire logic [DATA_W-1:0] cpu_data_i, // Processor write data
  input wire logic cpu_read_i, // High for read cycle
  input wire logic cpu_vma_i, // Valid memory address
  input wire logic e_clk_i, // Processor E clock
  input wire logic mid_strobe_i, // Mid-E-cycle strobe
  output logic [DATA_W-1:0] cpu_data_o, // Read data
  output logic cpu_data_oe_o, // Read data drive enable
  input wire logic other_listens_i, // Other plug-in addressed to listen
  input wire logic [LEVELS-1:1] level_onehot_i, // One-hot level
  input wire logic over_range_i, // Over-range comparator
  input wire logic talker_send_strobe_n_i, // Send strobe, low pulse
  input wire logic not_accepted_line_n_i, // Not-data-accepted line
  input wire logic service_request_line_n_i, // Service request line
  input wire logic [DATA_W-1:0] bus_data_i, // Plug-in bus data in
  output logic [DATA_W-1:0] bus_data_o, // Plug-in bus data out
  output logic bus_data_oe_o, // Bus driver enable
  output logic data_valid_line_n_o, // Data-valid line level
  output logic data_valid_line_oe_o, // Data-valid pulled low
  output logic port_a_control_output_n_o, // Port A control pulse
  output logic port_b_control_output_n_o, // Port B control pulse
  output logic byte_received_event_o, // Received byte interrupt
  output logic port_a_control_input_o, // Handshake done interrupt
  output logic port_b_interrupt_o, // Service request interrupt
  output logic diag_test_bit_o, // Diagnostic test line
  output logic handshake_abort_n_o, // Handshake abort line
  output logic right_unit_address_o, // Right unit address
  output logic left_unit_address_o, // Left unit address
  output logic remote_enable_line_n_o, // Remote enable, inverted
  output logic attention_line_n_o, // Attention, inverted
  output logic interface_clear_line_n_o, // Interface clear, inverted
  output logic end_identify_line_n_o, // End-identify, inverted
  output logic end_identify_line_oe_o // End-identify drive enable
);

  localparam int SW = ADDR_W + DATA_W * 2 + LEVELS + 8;

  typedef struct packed {
    logic strobe_prev;
    logic e_prev;
    logic send_prev;
    logic ndac_prev;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] port_a;
    logic [DATA_W-1:0] port_b;
    logic pa_ctl_n;
    logic pb_ctl_n;
    logic idle;
    logic dav_n;
    logic drv_oe;
    logic dav_oe;
    logic [CTL_EOI:CTL_REMOTE] mgmt_n;
    logic [DATA_W-1:0] rd_data;
    logic rd_oe;
    logic rx_irq;
    logic done_irq;
    logic srq_irq;
    logic eoi_oe;
  } pbi_state_type;

  pbi_state_type st_q;
  pbi_state_type st_d;

  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic [SW-1:0] syn_init;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  logic [DATA_W-1:0] s_bus;
  logic [LEVELS-1:1] s_level;
  logic s_read;
  logic s_vma;
  logic s_e;
  logic s_strobe;
  logic s_send_n;
  logic s_ndac_n;
  logic s_srq_n;
  logic s_over;
  logic s_listen;

  assign raw = {cpu_addr_i, cpu_data_i, bus_data_i, level_onehot_i,
                cpu_read_i, cpu_vma_i, e_clk_i, mid_strobe_i,
                talker_send_strobe_n_i, not_accepted_line_n_i,
                service_request_line_n_i, over_range_i, other_listens_i};
  // Idle-high levels for the active-low strobes and lines
  assign syn_init = {{(ADDR_W + DATA_W * 2 + LEVELS + 3){1'b0}},
                     4'hE, 1'b0};

  pbi_sync #(
    .WIDTH(SW)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(raw),
    .init_i(syn_init),
    .sync_o(syn)
  );

  assign {s_addr, s_data, s_bus, s_level, s_read, s_vma, s_e, s_strobe,
          s_send_n, s_ndac_n, s_srq_n, s_over, s_listen} = syn;

  logic plugin_port_select;
  logic gated_write_strobe;
  logic e_rise;
  logic send_rise;
  logic ndac_rise;
  logic rd_a;
  logic wr_b;
  logic [DATA_W-1:0] level_code;
  logic [CODE_W-1:0] bcd;

  always_comb begin
    plugin_port_select = s_vma
      && (s_addr[ADDR_W-1:SEL_LSB] == SEL_PLUGIN); // R01
    gated_write_strobe = plugin_port_select && s_strobe
      && !st_q.strobe_prev; // R18
    e_rise = s_e && !st_q.e_prev;
    send_rise = s_send_n && !st_q.send_prev;
    ndac_rise = s_ndac_n && !st_q.ndac_prev;
    rd_a = gated_write_strobe && s_read && (s_addr == ADDR_PORT_A);
    wr_b = gated_write_strobe && !s_read && (s_addr == ADDR_PORT_B);
    bcd = '0;
    for (int i = 1; i < LEVELS; i++) begin
      if (s_level[i]) begin
        bcd = CODE_W'(i); // R03
      end
    end
    level_code = BYTE_ZERO;
    level_code[CODE_W-1:0] = bcd;
    level_code[LVL_RANGE_BIT] = !s_over; // R04
  end

  always_comb begin
    st_d = st_q;
    st_d.strobe_prev = s_strobe;
    st_d.e_prev = s_e;
    st_d.send_prev = s_send_n;
    st_d.ndac_prev = s_ndac_n;
    if (gated_write_strobe && !s_read
        && (s_addr == ADDR_BUS_CONTROL)) begin
      st_d.ctrl = s_data; // R17 R18
    end
    if (send_rise) begin
      st_d.port_a = s_bus; // R05
    end
    if (wr_b) begin
      st_d.port_b = s_data;
    end
    if (e_rise) begin
      st_d.pa_ctl_n = 1'b1; // R07
      st_d.pb_ctl_n = 1'b1; // R10
    end
    if (rd_a && !s_listen) begin
      st_d.pa_ctl_n = 1'b0; // R07
    end
    if (wr_b && s_listen) begin
      st_d.pb_ctl_n = 1'b0; // R09
      st_d.idle = 1'b0; // R09
    end
    if (ndac_rise && !st_q.idle) begin
      st_d.idle = 1'b1; // R11 R12
    end
    if (!st_q.ctrl[CTL_HS_ABORT_N]) begin
      st_d.idle = 1'b1; // R15
    end
    // Clear on port A read; a new byte in the same cycle wins
    if (rd_a) begin
      st_d.rx_irq = 1'b0;
    end
    if (send_rise) begin
      st_d.rx_irq = 1'b1; // R06
    end
    if (wr_b) begin
      st_d.done_irq = 1'b0;
    end
    if (st_d.idle && !st_q.idle) begin
      st_d.done_irq = 1'b1; // R14
    end
    st_d.srq_irq = !s_srq_n; // R16
    st_d.dav_n = !(!st_d.pa_ctl_n
      || (!st_d.idle && st_d.pb_ctl_n)); // R08 R10 R13
    st_d.eoi_oe = !st_d.idle; // R21
    st_d.drv_oe = !st_d.idle; // R09 R12
    st_d.dav_oe = !st_d.dav_n;
    // Inverted copies kept in flops so the line outputs need no gate
    st_d.mgmt_n = ~st_d.ctrl[CTL_EOI:CTL_REMOTE]; // R20
    st_d.rd_oe = plugin_port_select && s_read && s_e
      && ((s_addr == ADDR_LEVEL_CODE) || (s_addr == ADDR_PORT_A));
    st_d.rd_data = (s_addr == ADDR_PORT_A) ? st_q.port_a
      : level_code; // R02
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q <= '0; // R22
      st_q.strobe_prev <= 1'b0;
      st_q.send_prev <= 1'b1;
      st_q.ndac_prev <= 1'b1;
      st_q.ctrl <= CTL_RESET;
      st_q.pa_ctl_n <= 1'b1;
      st_q.pb_ctl_n <= 1'b1;
      st_q.mgmt_n <= ~CTL_RESET[CTL_EOI:CTL_REMOTE];
      st_q.idle <= 1'b1; // R23
      st_q.dav_n <= 1'b1; // R23
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign cpu_data_o = st_q.rd_data;
  assign cpu_data_oe_o = st_q.rd_oe;
  assign bus_data_o = st_q.port_b;
  assign bus_data_oe_o = st_q.drv_oe; // R09 R12
  assign data_valid_line_n_o = st_q.dav_n;
  assign data_valid_line_oe_o = st_q.dav_oe;
  assign port_a_control_output_n_o = st_q.pa_ctl_n;
  assign port_b_control_output_n_o = st_q.pb_ctl_n;
  assign byte_received_event_o = st_q.rx_irq;
  assign port_a_control_input_o = st_q.done_irq;
  assign port_b_interrupt_o = st_q.srq_irq;
  assign diag_test_bit_o = st_q.ctrl[CTL_TEST]; // R19
  assign handshake_abort_n_o = st_q.ctrl[CTL_HS_ABORT_N]; // R19
  assign right_unit_address_o = st_q.ctrl[CTL_RIGHT_ADDR]; // R19
  assign left_unit_address_o = st_q.ctrl[CTL_LEFT_ADDR]; // R19
  assign remote_enable_line_n_o = st_q.mgmt_n[CTL_REMOTE]; // R20
  assign attention_line_n_o = st_q.mgmt_n[CTL_ATTN]; // R20
  assign interface_clear_line_n_o = st_q.mgmt_n[CTL_IFC]; // R20
  assign end_identify_line_n_o = st_q.mgmt_n[CTL_EOI]; // R20
  assign end_identify_line_oe_o = st_q.eoi_oe; // R21

  a_ctrl_write: assert property ( // R18
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && gated_write_strobe && !s_read
     && s_addr == ADDR_BUS_CONTROL) |=> st_q.ctrl == $past(s_data))
    else $error("control write not captured");
  a_pa_pulse_end: assert property ( // R07
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !st_q.pa_ctl_n && e_rise && !rd_a) |=> st_q.pa_ctl_n)
    else $error("port A pulse outlived E edge");
  a_pa_pulse_dav: assert property ( // R08
    @(posedge core_clk_i) disable iff (rst_i)
    !st_q.pa_ctl_n |-> !st_q.dav_n)
    else $error("data-valid not low with port A pulse");
  a_ndac_end: assert property ( // R12
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && ndac_rise && !st_q.idle) |=> st_q.idle && st_q.dav_n)
    else $error("handshake not ended by accept");
  a_abort_idle: assert property ( // R15
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !st_q.ctrl[CTL_HS_ABORT_N]) |=> st_q.idle)
    else $error("abort bit did not idle handshake");
  a_done_irq: assert property ( // R14
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(st_q.idle) |-> st_q.done_irq)
    else $error("handshake finish without interrupt");
  a_eoi_gate: assert property ( // R21
    @(posedge core_clk_i) disable iff (rst_i)
    st_q.idle |-> !end_identify_line_oe_o && !bus_data_oe_o)
    else $error("drivers on while idle");
  a_range_bit: assert property ( // R04
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i |=> st_q.rd_data[LVL_RANGE_BIT] == !$past(s_over)
      || $past(s_addr) == ADDR_PORT_A)
    else $error("over-range bit wrong");
  a_rx_irq: assert property ( // R05 R06
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && send_rise) |=> st_q.rx_irq
      && st_q.port_a == $past(s_bus))
    else $error("received byte not flagged");
  a_pb_pulse_end: assert property ( // R10
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !st_q.pb_ctl_n && e_rise && !wr_b) |=> st_q.pb_ctl_n)
    else $error("port B pulse outlived E edge");
  a_dav_valid: assert property ( // R10
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !st_q.pb_ctl_n && !st_q.idle && e_rise && !wr_b
     && !ndac_rise && st_q.ctrl[CTL_HS_ABORT_N]) |=> !st_q.dav_n)
    else $error("data-valid not asserted after port B pulse");
  a_srq_irq: assert property ( // R16
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !s_srq_n) |=> st_q.srq_irq)
    else $error("service request interrupt not raised");

endmodule : pbi_top

//--- core/pbi_pkg.sv
package pbi_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int LEVELS = 10;
  localparam int CODE_W = 4;

  // Function select: five upper address bits A10..A14
  localparam int SEL_LSB = 10;
  localparam logic [4:0] SEL_PLUGIN = 5'h0E;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_CODE = 15'h38EF;
  localparam logic [ADDR_W-1:0] ADDR_BUS_CONTROL = 15'h38F8;
  localparam logic [ADDR_W-1:0] ADDR_PORT_A = 15'h38F0;
  localparam logic [ADDR_W-1:0] ADDR_PORT_B = 15'h38F1;

  // Level code fields
  localparam int LVL_RANGE_BIT = 7;

  // Bus control fields
  localparam int CTL_TEST = 0;
  localparam int CTL_HS_ABORT_N = 1;
  localparam int CTL_RIGHT_ADDR = 2;
  localparam int CTL_LEFT_ADDR = 3;
  localparam int CTL_REMOTE = 4;
  localparam int CTL_ATTN = 5;
  localparam int CTL_IFC = 6;
  localparam int CTL_EOI = 7;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;

  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

endpackage : pbi_pkg

//--- core/pbi_sync.sv
`timescale 1ns/100ps

module pbi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic [WIDTH-1:0] async_i, // Pin levels
  input wire logic [WIDTH-1:0] init_i, // Constant reset level
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_width_check
    $error("pbi_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= init_i;
      sync_q <= init_i;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pbi_sync

//--- testbench/pbi_plugin_model.sv
`timescale 1ns/100ps

module pbi_plugin_model (
  input wire logic core_clk_i, // Core clock
  input wire logic dav_n_i, // Data-valid line
  input wire logic [7:0] bus_data_i, // Byte from the interface
  input wire logic listen_i, // Other unit addressed to listen
  input wire logic hold_ndac_i, // Listener never accepts
  input wire logic srq_i, // Ask for service
  output logic send_n_o, // Send strobe
  output logic ndac_n_o, // Not-accepted line
  output logic srq_n_o, // Service request line
  output logic [7:0] bus_data_o, // Byte from the talker
  output logic [7:0] taken_o // Last byte taken as listener
);
  initial begin
    send_n_o = 1'b1;
    ndac_n_o = 1'b0;
    bus_data_o = 8'h00;
    taken_o = 8'h00;
  end
  assign srq_n_o = !srq_i;
  // Byte is held across the whole low pulse, then scrambled
  task automatic send_byte(input logic [7:0] b);
    @(negedge core_clk_i);
    bus_data_o = b;
    repeat (2) @(negedge core_clk_i);
    send_n_o = 1'b0;
    repeat (4) @(negedge core_clk_i);
    send_n_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    bus_data_o = ~b;
  endtask : send_byte
  always @(negedge core_clk_i) begin
    if (listen_i && !hold_ndac_i && !dav_n_i && !ndac_n_o) begin
      taken_o <= bus_data_i;
      ndac_n_o <= 1'b1;
    end else if (dav_n_i) begin
      ndac_n_o <= 1'b0;
    end
  end
endmodule : pbi_plugin_model

//--- testbench/plugin_bus_interface_test.sv
`timescale 1ns/100ps

module plugin_bus_interface_test;
  import pbi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] addr = '0;
  logic [7:0] wd = '0;
  logic [7:0] rdata;
  logic [9:1] oh = '0;
  logic ec = 0, stb = 0, rd = 0, vma = 0, lsn = 0, ovr = 0, hold = 0;
  logic srq = 0, roe;
  logic ce = 1'b1;
  wire [7:0] dout, bout, bin, taken;
  wire send_n, ndac_n, srq_n, coe, boe, dav_n, dav_oe, pa_n, pb_n;
  wire rxe, hsd, sirq, tst, ab_n, ra, la, ren_n, atn_n, ifc_n, eoi_n, eoe;
  int miscompares = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  pbi_top pbi_top_inst (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .cpu_addr_i(addr), .cpu_data_i(wd), .cpu_read_i(rd), .cpu_vma_i(vma),
    .e_clk_i(ec), .mid_strobe_i(stb), .cpu_data_o(dout), .cpu_data_oe_o(coe),
    .other_listens_i(lsn), .level_onehot_i(oh), .over_range_i(ovr),
    .talker_send_strobe_n_i(send_n), .not_accepted_line_n_i(ndac_n),
    .service_request_line_n_i(srq_n), .bus_data_i(bin), .bus_data_o(bout),
    .bus_data_oe_o(boe), .data_valid_line_n_o(dav_n),
    .data_valid_line_oe_o(dav_oe), .port_a_control_output_n_o(pa_n),
    .port_b_control_output_n_o(pb_n), .byte_received_event_o(rxe),
    .port_a_control_input_o(hsd), .port_b_interrupt_o(sirq),
    .diag_test_bit_o(tst), .handshake_abort_n_o(ab_n),
    .right_unit_address_o(ra), .left_unit_address_o(la),
    .remote_enable_line_n_o(ren_n), .attention_line_n_o(atn_n),
    .interface_clear_line_n_o(ifc_n), .end_identify_line_n_o(eoi_n),
    .end_identify_line_oe_o(eoe));
  pbi_plugin_model pbi_plugin_model_inst (.core_clk_i(clk), .dav_n_i(dav_n),
    .bus_data_i(bout), .listen_i(lsn), .hold_ndac_i(hold), .srq_i(srq),
    .send_n_o(send_n), .ndac_n_o(ndac_n), .srq_n_o(srq_n), .bus_data_o(bin),
    .taken_o(taken));
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // One processor cycle: E high, strobe mid-cycle, read data sampled late
  task automatic acc(input logic [14:0] a, input logic [7:0] d, input logic r);
    @(negedge clk);
    addr = a;
    wd = d;
    rd = r;
    vma = 1'b1;
    ec = 1'b1;
    repeat (4) @(negedge clk);
    stb = 1'b1;
    repeat (4) @(negedge clk);
    rdata = dout;
    roe = coe;
    stb = 1'b0;
    ec = 1'b0;
    vma = 1'b0;
    repeat (6) @(negedge clk);
  endtask : acc
  function automatic logic [7:0] lines();
    return {~eoi_n, ~ifc_n, ~atn_n, ~ren_n, la, ra, ab_n, tst};
  endfunction : lines
  task automatic t_level;
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 2; j++) begin
        oh = (i == 0) ? 9'h000 : 9'h001 << (i - 1);
        ovr = j[0];
        acc(ADDR_LEVEL_CODE, 8'h00, 1'b1);
        chk("level oe", {7'h00, roe}, 8'h01);
        chk("level", rdata, {~ovr, 3'h0, 4'(i)});
      end
    end
    acc(15'h3CEF, 8'h00, 1'b1);
    chk("foreign oe", {7'h00, roe}, 8'h00);
    $display("level test done");
  endtask : t_level
  task automatic t_ctrl;
    logic [7:0] p[4] = '{8'h0F, 8'hF0, 8'hA5, 8'h5A};
    foreach (p[k]) begin
      acc(ADDR_BUS_CONTROL, p[k], 1'b0);
      chk("ctrl lines", lines(), p[k]);
    end
    acc(15'h3CF8, 8'hFF, 1'b0);
    chk("foreign write", lines(), 8'h5A);
    acc(ADDR_BUS_CONTROL, 8'h02, 1'b0);
    $display("control test done");
  endtask : t_ctrl
  task automatic t_recv;
    lsn = 1'b0;
    pbi_plugin_model_inst.send_byte(8'h5A);
    chk("rx event", {7'h00, rxe}, 8'h01);
    acc(ADDR_PORT_A, 8'h00, 1'b1);
    chk("rx byte", rdata, 8'h5A);
    chk("rx clear", {7'h00, rxe}, 8'h00);
    chk("pa dav", {6'h00, pa_n, dav_n}, 8'h00);
    acc(15'h0000, 8'h00, 1'b1);
    chk("pa dav end", {6'h00, pa_n, dav_n}, 8'h03);
    $display("receive test done");
  endtask : t_recv
  task automatic t_source;
    lsn = 1'b1;
    acc(ADDR_BUS_CONTROL, 8'h82, 1'b0);
    acc(ADDR_PORT_B, 8'hC3, 1'b0);
    chk("pb oe eoi dav", {4'h0, pb_n, boe, eoe, dav_n}, 8'h07);
    chk("bus byte", bout, 8'hC3);
    acc(15'h0000, 8'h00, 1'b1);
    chk("listener byte", taken, 8'hC3);
    chk("done", {4'h0, dav_n, boe, eoe, hsd}, 8'h09);
    $display("source test done");
  endtask : t_source
  task automatic t_abort;
    hold = 1'b1;
    acc(ADDR_PORT_B, 8'h3C, 1'b0);
    acc(15'h0000, 8'h00, 1'b1);
    chk("stuck", {5'h00, hsd, dav_n, boe}, 8'h01);
    acc(ADDR_BUS_CONTROL, 8'h80, 1'b0);
    chk("aborted", {5'h00, dav_n, boe, eoe}, 8'h04);
    hold = 1'b0;
    acc(ADDR_BUS_CONTROL, 8'h02, 1'b0);
    $display("abort test done");
  endtask : t_abort
  // A write issued while the clock enable is low must leave no trace
  task automatic t_freeze;
    ce = 1'b0;
    acc(ADDR_BUS_CONTROL, 8'h55, 1'b0);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk("frozen ctrl", lines(), 8'h02);
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_srq;
    srq = 1'b1;
    repeat (6) @(negedge clk);
    chk("srq irq", {7'h00, sirq}, 8'h01);
    srq = 1'b0;
    repeat (6) @(negedge clk);
    chk("srq idle", {7'h00, sirq}, 8'h00);
    $display("service test done");
  endtask : t_srq
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("rst", {dav_n, boe, eoe, rxe, hsd, dav_oe, pb_n, pa_n}, 8'h83);
    chk("reset lines", lines(), 8'h00);
    t_level();
    t_ctrl();
    t_recv();
    t_source();
    t_abort();
    t_freeze();
    t_srq();
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule : plugin_bus_interface_test
